// ==== uabp_top.sv ====
// Serial channel buffers, shifters and port one pin routing.
// Behaviour
// RQ1: Receive buffer loads each complete received byte.
// RQ2: Seven bit lsb-first: bits 0-6, top zero.
// RQ3: Seven bit msb-first: bits 1-7, bottom zero.
// RQ4: Overrun keeps the old receive buffer contents.
// RQ5: Receive buffer read only, resets to all ones.
// RQ6: Writing the transmit buffer starts transmission.
// RQ7: Transmit buffer read/write, resets to all ones.
// RQ8: Software never writes while buffer full.
// RQ9: Software never refreshes buffer while channel active.
// RQ10: Software waits one base clock after enable.
// RQ11: Copy after write, or at previous frame end.
// RQ12: Load and shift on base clock falling edges.
// RQ13: Shifters convert serial data, hidden from software.
// RQ14: Function bit six routes this channel to pin.
// RQ15: Function bit three routes other channel to pin.
// RQ16: Direction bit zero drives, one receives.
// RQ17: Software clears output pin direction bit.
// RQ18: Software sets input pin direction bit.
// RQ19: Full flag sets on write, clears on copy.
`timescale 1ns/10ps
`default_nettype none
module uabp_top #(
  parameter int unsigned BASE_DIV  = uabp_pkg::BASE_DIV_DFLT,
  parameter int unsigned BIT_TICKS = uabp_pkg::BIT_TICKS_DFLT
) (
  input  wire logic        clk_i,            // System clock.
  input  wire logic        resetn_i,         // Asynchronous reset, active low.
  input  wire logic [15:0] addr_i,           // Byte address of the access.
  input  wire logic        wr_i,             // Write strobe, one cycle.
  input  wire logic        rd_i,             // Read strobe, one cycle.
  input  wire logic [7:0]  wdata_i,          // Write data.
  output logic      [7:0]  rdata_o,          // Read data, valid the cycle after rd_i.
  input  wire logic [7:0]  port_latch_i,     // Port one output latch and other pin sources.
  input  wire logic        other_uart_out_i, // Other channel's serial output.
  input  wire logic [7:0]  port_pin_i,       // Port one pin levels.
  output logic      [7:0]  port_pin_o,       // Port one pin drive levels.
  output logic      [7:0]  port_pin_oe_o,    // Port one output enables, high drives.
  output logic             tx_end_o          // One cycle pulse at the end of each frame.
);
  localparam int unsigned DW = $clog2(BASE_DIV + 1);
  localparam int unsigned CW = $clog2(BIT_TICKS);
  localparam logic [DW-1:0] DIV_LAST = DW'(BASE_DIV - 1);
  localparam logic [CW-1:0] LAST_TICK = CW'(BIT_TICKS - 1);

  // Parameter sanity: the receiver needs a middle sample point.
  if (BASE_DIV < 1 || BIT_TICKS < 4) begin : g_bad_param
    $error("uabp_top: BASE_DIV must be at least 1 and BIT_TICKS at least 4");
  end

  // ----------------------------------------------------------------------
  // Registers visible to software, and the hidden unread flag
  // ----------------------------------------------------------------------
  logic [7:0] pfs_r, pfs_nxt;   // Pin function select.
  logic [7:0] dir_r, dir_nxt;   // Port one direction.
  logic [7:0] rxb_r, rxb_nxt;   // Receive holding buffer.
  logic [7:0] txb_r, txb_nxt;   // Transmit holding buffer.
  logic [7:0] op_r, op_nxt;     // Channel operation register.
  logic       txbf_r, txbf_nxt; // Transmit buffer full flag.
  logic       ovr_r, ovr_nxt;   // Sticky overrun flag.
  logic       unrd_r, unrd_nxt; // Receive buffer holds an unread byte.
  logic [7:0] rd_r, rd_nxt;     // Read data register.

  // ----------------------------------------------------------------------
  // Base clock and transmit shifter
  // ----------------------------------------------------------------------
  logic [DW-1:0] div_r, div_nxt;    // Half period divider.
  logic          ph_r, ph_nxt;      // Base clock phase.
  logic          fall;              // Base clock falling edge pulse.
  uabp_pkg::uabp_tx_state_t tst_r, tst_nxt; // Transmit state.
  logic [9:0]    fr_r, fr_nxt;      // Transmit shifter frame.
  logic [3:0]    nb_r, nb_nxt;      // Frame bits still to send.
  logic [CW-1:0] ttc_r, ttc_nxt;    // Base clocks within a bit.
  logic          txl_r, txl_nxt;    // Transmit line level.
  logic          end_r, end_nxt;    // Frame end pulse.
  logic          load;              // Buffer to shifter copy this cycle.
  logic [7:0]    rev;               // Buffer in reversed bit order.
  logic [7:0]    pin_r, pin_nxt;    // Pin drive levels.
  logic [7:0]    oe_r, oe_nxt;      // Pin output enables.
  logic          pwr, tx_en, rx_en, last_bit;

  uabp_rx_if rxif ();

  assign pwr   = op_r[uabp_pkg::POWER_BIT];
  assign tx_en = pwr && op_r[uabp_pkg::TXE_BIT];
  assign rx_en = pwr && op_r[uabp_pkg::RXE_BIT];
  assign fall  = ph_r && (div_r == DIV_LAST);
  assign last_bit = (tst_r == uabp_pkg::TX_SHIFT) && fall && ttc_r == LAST_TICK && nb_r == 4'h1;
  // Copy on a falling edge: first frame when idle, or at the previous frame's end, see RQ11.
  assign load = txbf_r && tx_en && fall && (tst_r == uabp_pkg::TX_IDLE || last_bit); // see RQ12
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rev[i] = txb_r[7 - i];
    end
  end

  assign rxif.tick      = fall;
  assign rxif.enable    = rx_en;
  assign rxif.seven     = op_r[uabp_pkg::SEVEN_BIT];
  assign rxif.msb_first = op_r[uabp_pkg::MSB_FIRST_BIT];
  assign rxif.serial_in = port_pin_i[uabp_pkg::IN_PIN];

  uabp_rx_shifter #(.BIT_TICKS(BIT_TICKS)) u_rx (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .rx       (rxif)
  );

  // Register access next values; hardware sets win over software clears.
  always_comb begin
    pfs_nxt  = pfs_r;
    dir_nxt  = dir_r;
    txb_nxt  = txb_r;
    op_nxt   = op_r;
    rxb_nxt  = rxb_r;
    rd_nxt   = rd_r;
    unrd_nxt = unrd_r;
    ovr_nxt  = ovr_r;
    txbf_nxt = txbf_r;
    if (wr_i) begin
      unique case (addr_i)
        uabp_pkg::ADDR_PIN_FUNC: begin
          // Only the two routing bits exist.
          pfs_nxt = wdata_i & 8'h48;
        end
        uabp_pkg::ADDR_PORT_DIR: dir_nxt = wdata_i;
        uabp_pkg::ADDR_TX_BUF: begin
          txb_nxt  = wdata_i;                       // see RQ7
          txbf_nxt = tx_en ? 1'b1 : txbf_r;          // see RQ6, RQ19
        end
        uabp_pkg::ADDR_CHAN_OP: op_nxt = wdata_i;
        default: begin
          // Receive buffer and status ignore writes, see RQ5.
        end
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        uabp_pkg::ADDR_PIN_FUNC: rd_nxt = pfs_r;
        uabp_pkg::ADDR_PORT_DIR: rd_nxt = dir_r;
        uabp_pkg::ADDR_RX_BUF: begin
          rd_nxt   = rxb_r;
          unrd_nxt = 1'b0;
        end
        uabp_pkg::ADDR_TX_BUF:  rd_nxt = txb_r;
        uabp_pkg::ADDR_CHAN_OP: rd_nxt = op_r;
        uabp_pkg::ADDR_TX_STAT: begin
          rd_nxt = {5'h00, ovr_r, txbf_r, tst_r == uabp_pkg::TX_SHIFT};
          ovr_nxt = 1'b0;
        end
        default: rd_nxt = uabp_pkg::ZERO_BYTE;
      endcase
    end
    if (rxif.done) begin
      if (unrd_r) begin
        ovr_nxt = 1'b1;                              // see RQ4
      end else begin
        rxb_nxt  = rxif.data;                        // see RQ1
        unrd_nxt = 1'b1;
      end
    end
    if (load) begin
      txbf_nxt = 1'b0;                               // see RQ19
    end
    if (!tx_en) begin
      txbf_nxt = 1'b0;
    end
  end

  // Transmit shifter and base clock next values.
  always_comb begin
    div_nxt = (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
    ph_nxt  = (div_r == DIV_LAST) ? !ph_r : ph_r;
    tst_nxt = tst_r;
    fr_nxt  = fr_r;
    nb_nxt  = nb_r;
    ttc_nxt = ttc_r;
    end_nxt = 1'b0;
    if (!pwr) begin
      div_nxt = '0;
      ph_nxt  = 1'b0;
      tst_nxt = uabp_pkg::TX_IDLE;
    end else if (tst_r == uabp_pkg::TX_SHIFT && fall) begin
      ttc_nxt = ttc_r + 1'b1;
      if (ttc_r == LAST_TICK) begin
        ttc_nxt = '0;
        fr_nxt  = {1'b1, fr_r[9:1]};
        nb_nxt  = nb_r - 1'b1;
        if (nb_r == 4'h1) begin
          tst_nxt = uabp_pkg::TX_IDLE;
          end_nxt = 1'b1;
        end
      end
    end
    if (load) begin
      // Hidden shifter, sent from bit zero; msb-first loads the reversed buffer, see RQ13.
      tst_nxt = uabp_pkg::TX_SHIFT;
      ttc_nxt = '0;
      if (op_r[uabp_pkg::SEVEN_BIT]) begin
        fr_nxt = {2'b11, op_r[uabp_pkg::MSB_FIRST_BIT] ? rev[6:0] : txb_r[6:0], 1'b0};
        nb_nxt = uabp_pkg::FRAME_BITS_7;
      end else begin
        fr_nxt = {1'b1, op_r[uabp_pkg::MSB_FIRST_BIT] ? rev : txb_r, 1'b0};
        nb_nxt = uabp_pkg::FRAME_BITS_8;
      end
    end
    txl_nxt = (tst_nxt == uabp_pkg::TX_SHIFT) ? fr_nxt[0] : 1'b1;
  end

  // Pin routing next values.
  always_comb begin
    pin_nxt = port_latch_i;
    oe_nxt  = ~dir_r;                                // see RQ16
    pin_nxt[uabp_pkg::OUT_PIN] = pfs_r[uabp_pkg::OUT_ROUTE_BIT] ? txl_r
                                 : port_latch_i[uabp_pkg::OUT_PIN];   // see RQ14
    pin_nxt[uabp_pkg::OTHER_PIN] = pfs_r[uabp_pkg::OTHER_ROUTE_BIT] ? other_uart_out_i
                                   : port_latch_i[uabp_pkg::OTHER_PIN]; // see RQ15
  end

  // All registers of the block.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pfs_r  <= uabp_pkg::PIN_FUNC_RST;
      dir_r  <= uabp_pkg::PORT_DIR_RST;
      rxb_r  <= uabp_pkg::RX_BUF_RST;                // see RQ5
      txb_r  <= uabp_pkg::TX_BUF_RST;                // see RQ7
      op_r   <= uabp_pkg::CHAN_OP_RST;
      rd_r   <= uabp_pkg::ZERO_BYTE;
      txbf_r <= 1'b0;
      ovr_r  <= 1'b0;
      unrd_r <= 1'b0;
      div_r  <= '0;
      ph_r   <= 1'b0;
      tst_r  <= uabp_pkg::TX_IDLE;
      fr_r   <= 10'h3ff;
      nb_r   <= 4'h0;
      ttc_r  <= '0;
      txl_r  <= 1'b1;
      end_r  <= 1'b0;
      pin_r  <= uabp_pkg::ZERO_BYTE;
      oe_r   <= uabp_pkg::ZERO_BYTE;
    end else begin
      pfs_r  <= pfs_nxt;
      dir_r  <= dir_nxt;
      rxb_r  <= rxb_nxt;
      txb_r  <= txb_nxt;
      op_r   <= op_nxt;
      rd_r   <= rd_nxt;
      txbf_r <= txbf_nxt;
      ovr_r  <= ovr_nxt;
      unrd_r <= unrd_nxt;
      div_r  <= div_nxt;
      ph_r   <= ph_nxt;
      tst_r  <= tst_nxt;
      fr_r   <= fr_nxt;
      nb_r   <= nb_nxt;
      ttc_r  <= ttc_nxt;
      txl_r  <= txl_nxt;
      end_r  <= end_nxt;
      pin_r  <= pin_nxt;
      oe_r   <= oe_nxt;
    end
  end

  assign rdata_o       = rd_r;
  assign port_pin_o    = pin_r;
  assign port_pin_oe_o = oe_r;
  assign tx_end_o      = end_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  rx_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ1
    rxif.done && !unrd_r |=> rxb_r == $past(rxif.data) && unrd_r)
    else $error("completed byte not moved to the receive buffer");
  overrun_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ4
    rxif.done && unrd_r |=> $stable(rxb_r) && ovr_r)
    else $error("overrun replaced the receive buffer");
  rxb_nowrite_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ5
    wr_i && addr_i == uabp_pkg::ADDR_RX_BUF && !rxif.done |=> $stable(rxb_r))
    else $error("write changed the receive buffer");
  tx_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ6
    wr_i && addr_i == uabp_pkg::ADDR_TX_BUF && tx_en && !load && tst_r == uabp_pkg::TX_IDLE
    |=> txbf_r ##[1:64] tst_r == uabp_pkg::TX_SHIFT)
    else $error("buffer write did not start a frame");
  tx_load_fall_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ12
    $rose(tst_r == uabp_pkg::TX_SHIFT) |-> $past(fall) && !txbf_r)
    else $error("shifter loaded off a falling edge");
  frame_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ11
    $rose(tst_r == uabp_pkg::TX_SHIFT) |=> !txl_r)
    else $error("frame did not begin with a start bit");
  pin_route_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ14
    pfs_r[uabp_pkg::OUT_ROUTE_BIT] && $stable(pfs_r) ##1 $stable(txl_r)
    |-> port_pin_o[uabp_pkg::OUT_PIN] == txl_r)
    else $error("routed pin does not carry the transmit line");
  pin_dir_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ16
    $stable(dir_r) |=> port_pin_oe_o == ~$past(dir_r))
    else $error("pin enable disagrees with direction bit");
  tx_cont_c: cover property (@(posedge clk_i) disable iff (!resetn_i) last_bit && load);
  overrun_c: cover property (@(posedge clk_i) disable iff (!resetn_i) rxif.done && unrd_r);
  rx_seven_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    rxif.done && rxif.seven && rxif.msb_first);
endmodule
`default_nettype wire

// ==== uabp_pkg.sv ====
// Shared constants and types for the asynchronous serial buffer and pin block.
`default_nettype none
package uabp_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_PIN_FUNC = 16'hff20;  // Pin function select register.
  localparam logic [15:0] ADDR_PORT_DIR = 16'hff21;  // Port one direction register.
  localparam logic [15:0] ADDR_RX_BUF   = 16'hff18;  // Receive holding buffer.
  localparam logic [15:0] ADDR_TX_BUF   = 16'hff19;  // Transmit holding buffer.
  localparam logic [15:0] ADDR_CHAN_OP  = 16'hff1a;  // Channel operation register.
  localparam logic [15:0] ADDR_TX_STAT  = 16'hff1b;  // Transmission status register.

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIN_FUNC_RST = 8'h00;  // All shared pins stay general port.
  localparam logic [7:0] PORT_DIR_RST = 8'hff;  // All port one pins start as inputs.
  localparam logic [7:0] RX_BUF_RST   = 8'hff;  // Receive buffer after reset.
  localparam logic [7:0] TX_BUF_RST   = 8'hff;  // Transmit buffer after reset.
  localparam logic [7:0] CHAN_OP_RST  = 8'h00;  // Channel powered down after reset.
  localparam logic [7:0] ZERO_BYTE    = 8'h00;  // Value of unmapped or reserved reads.

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned POWER_BIT     = 7;  // Channel power on.
  localparam int unsigned TXE_BIT       = 6;  // Transmit enable.
  localparam int unsigned RXE_BIT       = 5;  // Receive enable.
  localparam int unsigned MSB_FIRST_BIT = 3;  // Most significant bit first.
  localparam int unsigned SEVEN_BIT     = 2;  // Seven bit characters.
  localparam int unsigned OVERRUN_BIT   = 2;  // Sticky overrun flag in status.
  localparam int unsigned TXBF_BIT      = 1;  // Transmit buffer full flag.
  localparam int unsigned TX_BUSY_BIT   = 0;  // Transmit shifter busy.
  localparam int unsigned OUT_ROUTE_BIT = 6;  // Routes this channel's output to pin six.
  localparam int unsigned OTHER_ROUTE_BIT = 3;  // Routes the other channel's output to pin three.
  localparam int unsigned OUT_PIN       = 6;  // Serial output pin of port one.
  localparam int unsigned IN_PIN        = 5;  // Serial input pin of port one.
  localparam int unsigned OTHER_PIN     = 3;  // Pin shared with the other channel.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 5;   // System clock period.
  localparam int unsigned BASE_DIV_DFLT   = 2;   // System clocks per base clock half period.
  localparam int unsigned BIT_TICKS_DFLT  = 16;  // Base clocks per serial bit.
  localparam logic [3:0]  FRAME_BITS_8    = 4'ha; // Start, eight data bits, stop.
  localparam logic [3:0]  FRAME_BITS_7    = 4'h9; // Start, seven data bits, stop.
  localparam logic [3:0]  DATA_BITS_8     = 4'h8; // Data bits of a long character.
  localparam logic [3:0]  DATA_BITS_7     = 4'h7; // Data bits of a short character.

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uabp_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} uabp_tx_state_t;

endpackage
`default_nettype wire

// ==== uabp_rx_if.sv ====
// Interface between the register core and the receive shifter.
`timescale 1ns/10ps
`default_nettype none
interface uabp_rx_if;
  logic       tick;       // Base clock falling edge pulse.
  logic       enable;     // Receiver powered and enabled.
  logic       seven;      // Seven bit characters.
  logic       msb_first;  // Most significant bit first.
  logic       serial_in;  // Serial input line level.
  logic       done;       // One cycle pulse: a character is complete.
  logic [7:0] data;       // Packed character, valid with done.

  // ----------------------------------------------------------------------
  // Views
  // ----------------------------------------------------------------------
  modport shifter (input tick, enable, seven, msb_first, serial_in, output done, data);
  modport core    (output tick, enable, seven, msb_first, serial_in, input done, data);
endinterface
`default_nettype wire

// ==== uabp_rx_shifter.sv ====
// Receive shifter: turns the serial input into a packed character.
`timescale 1ns/10ps
`default_nettype none
module uabp_rx_shifter #(
  parameter int unsigned BIT_TICKS = uabp_pkg::BIT_TICKS_DFLT
) (
  input  wire logic    clk_i,      // System clock.
  input  wire logic    resetn_i,   // Asynchronous reset, active low.
  uabp_rx_if.shifter   rx          // Link to the register core.
);
  localparam int unsigned CW = $clog2(BIT_TICKS);
  localparam logic [CW-1:0] LAST_TICK = CW'(BIT_TICKS - 1);
  localparam logic [CW-1:0] HALF_TICK = CW'(BIT_TICKS / 2 - 1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  uabp_pkg::uabp_rx_state_t st_r, st_nxt;     // Receive sequence state.
  logic [CW-1:0]            tc_r, tc_nxt;     // Base clocks within a bit.
  logic [3:0]               bc_r, bc_nxt;     // Data bits received.
  logic [7:0]               sh_r, sh_nxt;     // Receive shifter contents.
  logic                     done_r, done_nxt; // Completion pulse.
  logic [7:0]               pk_r, pk_nxt;     // Packed character.
  logic [3:0]               len;              // Data bits expected.

  assign len     = rx.seven ? uabp_pkg::DATA_BITS_7 : uabp_pkg::DATA_BITS_8;
  assign rx.done = done_r;
  assign rx.data = pk_r;

  // Next state: samples each bit in its middle; the stop bit is not checked here.
  always_comb begin
    st_nxt   = st_r;
    tc_nxt   = tc_r;
    bc_nxt   = bc_r;
    sh_nxt   = sh_r;
    pk_nxt   = pk_r;
    done_nxt = 1'b0;
    if (!rx.enable) begin
      st_nxt = uabp_pkg::RX_IDLE;
    end else if (rx.tick) begin
      unique case (st_r)
        uabp_pkg::RX_IDLE: begin
          // A low level may be a start bit.
          if (!rx.serial_in) begin
            st_nxt = uabp_pkg::RX_START;
            tc_nxt = '0;
          end
        end
        uabp_pkg::RX_START: begin
          tc_nxt = tc_r + 1'b1;
          if (tc_r == HALF_TICK) begin
            // A glitch shorter than half a bit is dropped.
            st_nxt = rx.serial_in ? uabp_pkg::RX_IDLE : uabp_pkg::RX_DATA;
            tc_nxt = '0;
            bc_nxt = '0;
          end
        end
        uabp_pkg::RX_DATA: begin
          tc_nxt = tc_r + 1'b1;
          if (tc_r == LAST_TICK) begin
            tc_nxt = '0;
            bc_nxt = bc_r + 1'b1;
            // Serial to parallel conversion, see RQ13.
            sh_nxt = rx.msb_first ? {sh_r[6:0], rx.serial_in} : {rx.serial_in, sh_r[7:1]};
            if (bc_r == len - 1'b1) begin
              st_nxt = uabp_pkg::RX_STOP;
            end
          end
        end
        uabp_pkg::RX_STOP: begin
          tc_nxt = tc_r + 1'b1;
          if (tc_r == LAST_TICK) begin
            st_nxt   = uabp_pkg::RX_IDLE;
            done_nxt = 1'b1;
            // Short characters pad with zero at the far end, see RQ2 and RQ3.
            if (!rx.seven) begin
              pk_nxt = sh_r;
            end else if (rx.msb_first) begin
              pk_nxt = {sh_r[6:0], 1'b0};
            end else begin
              pk_nxt = {1'b0, sh_r[7:1]};
            end
          end
        end
      endcase
    end
  end

  // Registers of the receive sequence.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r   <= uabp_pkg::RX_IDLE;
      tc_r   <= '0;
      bc_r   <= '0;
      sh_r   <= uabp_pkg::ZERO_BYTE;
      pk_r   <= uabp_pkg::ZERO_BYTE;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tc_r   <= tc_nxt;
      bc_r   <= bc_nxt;
      sh_r   <= sh_nxt;
      pk_r   <= pk_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  seven_lsb_pad_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ2
    done_r && rx.seven && !rx.msb_first |-> pk_r[7] == 1'b0)
    else $error("short lsb-first character has a high top bit");
  seven_msb_pad_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // see RQ3
    done_r && rx.seven && rx.msb_first |-> pk_r[0] == 1'b0)
    else $error("short msb-first character has a high low bit");
endmodule
`default_nettype wire

// ==== uabp_remote.sv ====
// Remote serial node model that sends frames into the block's serial input.
`timescale 1ns/10ps
`default_nettype none
module uabp_remote #(
  parameter int unsigned BIT_CLKS = 8  // System clocks per serial bit.
) (
  input  wire logic clk_i,  // System clock.
  output var  logic line_o  // Serial line, idles at the high mark level.
);
  initial line_o = 1'b1;
  // Start low, data bits in the chosen order, stop high; every bit holds BIT_CLKS clocks.
  task automatic send(input logic [7:0] d, input int nb, input logic msb);
    for (int i = 0; i <= nb + 1; i++) begin
      @(negedge clk_i);
      if (i == 0) line_o = 1'b0;
      else if (i == nb + 1) line_o = 1'b1;
      else line_o = msb ? d[nb - i] : d[i - 1];
      repeat (BIT_CLKS - 1) @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== test_uabp_top.sv ====
// Self-checking testbench for the serial buffer and pin block.
`timescale 1ns/10ps
`default_nettype none
module test_uabp_top;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  wdata_i = 8'h00;
  logic [7:0]  port_latch_i = 8'h00;
  logic        other_uart_out_i = 1'b0;
  logic [7:0]  rdata_o, port_pin_o, port_pin_oe_o;
  logic        tx_end_o, line;
  int          err_count = 0;
  int          check_count = 0;
  always #2.5 clk_i = ~clk_i;
  // Bit time is 4 base ticks of 2 clocks, so 8 clocks, keeping frames short.
  uabp_top #(.BASE_DIV(1), .BIT_TICKS(4)) u_uabp_top (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .port_latch_i(port_latch_i), .other_uart_out_i(other_uart_out_i),
    .port_pin_i({2'b11, line, 5'h1f}), .port_pin_o(port_pin_o),
    .port_pin_oe_o(port_pin_oe_o), .tx_end_o(tx_end_o));
  uabp_remote #(.BIT_CLKS(8)) u_uabp_remote (.clk_i(clk_i), .line_o(line));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  // Reads one byte and compares it once the registered answer has settled.
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    @(negedge clk_i);
    chk("rdata", e, rdata_o);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic test_regs();
    rd(16'hff18, 8'hff);
    rd(16'hff19, 8'hff);
    rd(16'hff20, 8'h00);
    rd(16'hff21, 8'hff);
    wr(16'hff18, 8'h00);
    rd(16'hff18, 8'hff);
    rd(16'hff30, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_pins();
    wr(16'hff21, 8'hb7);
    repeat (2) @(negedge clk_i);
    chk("pin enables", 8'h48, port_pin_oe_o);
    chk("pin six latch", 8'h00, {7'h0, port_pin_o[6]});
    other_uart_out_i = 1'b1;
    wr(16'hff20, 8'h48);
    repeat (2) @(negedge clk_i);
    chk("pin six idle", 8'h01, {7'h0, port_pin_o[6]});
    chk("pin three", 8'h01, {7'h0, port_pin_o[3]});
    $display("test pins done");
  endtask
  // Sends one byte and samples the pin in the middle of every bit.
  task automatic test_tx();
    logic [9:0] f;
    int n;
    int e;
    f = {1'b1, 8'ha5, 1'b0};
    e = 0;
    wr(16'hff1a, 8'hc0);
    repeat (4) @(negedge clk_i);
    wr(16'hff19, 8'ha5);
    n = 0;
    while (port_pin_o[6] !== 1'b0 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 10; i++) begin
      chk("tx bit", {7'h0, f[i]}, {7'h0, port_pin_o[6]});
      // Frame end pulses are counted while each bit stands on the pin.
      for (int k = 0; k < 8; k++) begin
        @(negedge clk_i);
        if (tx_end_o === 1'b1) e++;
      end
    end
    chk("tx end pulses", 8'h01, 8'(e));
    rd(16'hff19, 8'ha5);
    rd(16'hff1b, 8'h00);
    $display("test tx done");
  endtask
  task automatic rx_one(input logic [7:0] op, input logic [7:0] d, input int nb,
                        input logic msb, input logic [7:0] e);
    wr(16'hff1a, op);
    u_uabp_remote.send(d, nb, msb);
    repeat (10) @(negedge clk_i);
    rd(16'hff18, e);
  endtask
  task automatic test_rx();
    rx_one(8'ha0, 8'h3c, 8, 1'b0, 8'h3c);
    rx_one(8'ha4, 8'h55, 7, 1'b0, 8'h55);
    rx_one(8'hac, 8'h55, 7, 1'b1, 8'haa);
    wr(16'hff1a, 8'ha0);
    u_uabp_remote.send(8'h11, 8, 1'b0);
    rx_one(8'ha0, 8'h22, 8, 1'b0, 8'h11);
    rd(16'hff1b, 8'h04);
    $display("test rx done");
  endtask
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    test_regs();
    test_pins();
    test_tx();
    test_rx();
    stop_test();
  end
endmodule
`default_nettype wire
